// file: hdl/sscg_guard.sv
// vector state save/restore engine with control/status reserved-bit guard
// assumes a strobe register master that never waits and reads data one cycle later
//
// Contract
// - a save command writes floating-point, SIMD integer and vector state with the control/status word into one 512-byte image.
// - a restore command reloads the vector registers and the control/status word from the image.
// - save and restore also carry the floating-point stack and tag state, which covers the aliased SIMD integer registers.
// - writing a one to a reserved control/status bit raises a general-protection fault and the write is not done; while busy it is dropped without a fault.
// - the image holds the capability mask in bytes 28 to 31.
// - a capability field of zero means the default mask 0000ffbf, with the denormals-as-zero bit 6 reserved.
// - every zero bit of the effective mask is a reserved control/status bit.
// - every one bit of the effective mask is an implemented, writable control/status bit.
// - vector-only operations stay correct when interleaved with stack or SIMD integer use, the state being separate.
// - vector data are kept in native precision and never widened.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sscg_guard #(
  parameter logic [31:0] CAP_MASK_FIELD = 32'h0000_0000
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire sscg_pkg::sscg_bus_req_t     busReq,
  output var  logic [sscg_pkg::DATA_W-1:0] readData,
  output var  logic                        irq,
  output var  logic                        protFault,
  output var  logic                        busy
);
  import sscg_pkg::*;

  // ==========================================================================
  // effective capability mask
  // default mask for a zero field
  localparam logic [DATA_W-1:0] EFF_MASK = sscg_eff_mask(CAP_MASK_FIELD);

  sscg_state_t       state;
  sscg_state_t       next_state;
  sscg_mem_req_t     archReq;
  sscg_mem_req_t     imgReq;
  logic [DATA_W-1:0] archRd;
  logic [DATA_W-1:0] imgRd;
  logic [NUM_EV-1:0] setEv;
  logic [NUM_EV-1:0] clrEv;
  logic [DATA_W-1:0] saveWord;
  logic              idle;
  logic              loadBad;
  logic              imageBad;
  logic [7:0]        imgRdTag;

  // ==========================================================================
  // architectural state and save image memories
  // separate register regions
  sscg_word_mem #(.DEPTH(IMG_WORDS)) archMem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (archReq),
    .rdata   (archRd)
  );

  sscg_word_mem #(.DEPTH(IMG_WORDS)) imgMem (
    .clk     (clk),
    .sys_rst (sys_rst),
    .req     (imgReq),
    .rdata   (imgRd)
  );

  assign idle     = state.st == ENG_IDLE;
  assign imgRdTag = imgRd[7:0];
  assign loadBad  = sscg_has_reserved(busReq.wdata, EFF_MASK);
  assign imageBad = sscg_has_reserved(imgRd, EFF_MASK);

  // ==========================================================================
  // next state
  always_comb begin
    next_state          = state;
    next_state.readData = '0;
    archReq             = '0;
    imgReq              = '0;
    archReq.addr        = state.archPtr;
    imgReq.addr         = state.imgPtr;
    setEv               = '0;
    clrEv               = '0;
    saveWord            = archRd;

    // register writes
    if (busReq.wr) begin
      if (busReq.addr == OFF_IRQ_MASK) begin
        next_state.irqMask = busReq.wdata[NUM_EV-1:0];
      end
      if (idle) begin
        case (busReq.addr)
          OFF_CMD: begin
            if (busReq.wdata[CMD_SAVE_BIT]) begin
              next_state.st  = ENG_SAVE_RD;
              next_state.idx = '0;
            end else if (busReq.wdata[CMD_RESTORE_BIT]) begin
              next_state.st = ENG_RST_CHK;
            end
            if (busReq.wdata[CMD_EMPTY_BIT]) begin
              next_state.tagWord = TAG_EMPTY;
            end
          end
          OFF_CSR: begin
            if (loadBad) begin
              setEv[EV_FAULT] = 1'b1;
            end else begin
              next_state.csr = busReq.wdata;
            end
          end
          OFF_ARCH_PTR: next_state.archPtr = busReq.wdata[IDX_W-1:0];
          OFF_ARCH_DATA: begin
            archReq.we    = 1'b1;
            archReq.wdata = busReq.wdata;
          end
          OFF_IMG_PTR: next_state.imgPtr = busReq.wdata[IDX_W-1:0];
          OFF_IMG_DATA: begin
            imgReq.we    = 1'b1;
            imgReq.wdata = busReq.wdata;
          end
          default: begin
          end
        endcase
      end
    end

    // register reads
    if (busReq.rd) begin
      case (busReq.addr)
        OFF_STATUS: begin
          next_state.readData = {28'h0000_000, !idle, state.status};
          clrEv               = '1;
        end
        OFF_IRQ_MASK:  next_state.readData = {29'h0000_0000, state.irqMask};
        OFF_CSR:       next_state.readData = state.csr;
        OFF_CAP:       next_state.readData = EFF_MASK;
        OFF_ARCH_PTR:  next_state.readData = {25'h000_0000, state.archPtr};
        OFF_ARCH_DATA: next_state.readData = idle ? archRd : '0;
        OFF_IMG_PTR:   next_state.readData = {25'h000_0000, state.imgPtr};
        OFF_IMG_DATA:  next_state.readData = idle ? imgRd : '0;
        default:       next_state.readData = '0;
      endcase
    end

    // save and restore engine
    case (state.st)
      ENG_IDLE: begin
      end
      ENG_SAVE_RD: begin
        archReq.addr  = state.idx;
        next_state.st = ENG_SAVE_WR;
      end
      ENG_SAVE_WR: begin
        if (state.idx == IMG_TAG_IDX) begin
          saveWord = {24'h00_0000, state.tagWord};
        end else if (state.idx == IMG_CSR_IDX) begin
          saveWord = state.csr;
        end else if (state.idx == IMG_CAPMASK_IDX) begin
          // mask in bytes 28 to 31
          saveWord = CAP_MASK_FIELD;
        end
        archReq.addr = state.idx;
        imgReq.we    = 1'b1;
        imgReq.addr  = state.idx;
        imgReq.wdata = saveWord;
        if (state.idx == IMG_LAST_IDX) begin
          next_state.st         = ENG_IDLE;
          setEv[EV_SAVE_DONE]   = 1'b1;
        end else begin
          next_state.idx = state.idx + 7'h01;
          next_state.st  = ENG_SAVE_RD;
        end
      end
      ENG_RST_CHK: begin
        imgReq.addr   = IMG_CSR_IDX;
        next_state.st = ENG_RST_EVAL;
      end
      ENG_RST_EVAL: begin
        if (imageBad) begin
          setEv[EV_FAULT] = 1'b1;
          next_state.st   = ENG_IDLE;
        end else begin
          next_state.idx = '0;
          next_state.st  = ENG_RST_RD;
        end
      end
      ENG_RST_RD: begin
        imgReq.addr   = state.idx;
        next_state.st = ENG_RST_WR;
      end
      ENG_RST_WR: begin
        imgReq.addr = state.idx;
        if (state.idx == IMG_TAG_IDX) begin
          next_state.tagWord = imgRdTag;
        end else if (state.idx == IMG_CSR_IDX) begin
          next_state.csr = imgRd;
        end else if (state.idx != IMG_CAPMASK_IDX) begin
          archReq.we    = 1'b1;
          archReq.addr  = state.idx;
          archReq.wdata = imgRd;
        end
        if (state.idx == IMG_LAST_IDX) begin
          next_state.st          = ENG_IDLE;
          setEv[EV_RESTORE_DONE] = 1'b1;
        end else begin
          next_state.idx = state.idx + 7'h01;
          next_state.st  = ENG_RST_RD;
        end
      end
      default: next_state.st = ENG_IDLE;
    endcase

    // sticky events, set wins over read clear
    next_state.status    = (state.status & ~clrEv) | setEv;
    next_state.irq       = |(next_state.status & next_state.irqMask);
    next_state.protFault = setEv[EV_FAULT];
    next_state.busy      = next_state.st != ENG_IDLE;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= '0;
      state.st      <= ENG_IDLE;
      state.csr     <= CSR_RESET;
      state.tagWord <= TAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign readData  = state.readData;
  assign irq       = state.irq;
  assign protFault = state.protFault;
  assign busy      = state.busy;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sSaveCmd;
    busReq.wr && idle && busReq.addr == OFF_CMD && busReq.wdata[CMD_SAVE_BIT];
  endsequence

  sequence sLoadWr;
    busReq.wr && idle && busReq.addr == OFF_CSR;
  endsequence

  sequence sSaveStep;
    state.st == ENG_SAVE_WR && state.idx != IMG_LAST_IDX;
  endsequence

  AST_SAVE_START: assert property (sSaveCmd |=> state.st == ENG_SAVE_RD && state.idx == 7'h00 && busy)
    else $error("save did not start at word zero");

  AST_SAVE_STEP: assert property (sSaveStep
    |=> state.st == ENG_SAVE_RD && state.idx == $past(state.idx) + 7'h01)
    else $error("save skipped a word");

  AST_SAVE_END: assert property (state.st == ENG_SAVE_WR && state.idx == IMG_LAST_IDX
    |=> idle && state.status[EV_SAVE_DONE] && !busy)
    else $error("save did not finish after last word");

  AST_IMG_CAP: assert property (state.st == ENG_SAVE_WR && state.idx == IMG_CAPMASK_IDX
    |-> imgReq.we && imgReq.wdata == CAP_MASK_FIELD && imgReq.addr == 7'h07)
    else $error("capability mask not in bytes 28 to 31");

  AST_RESTORE_CSR: assert property (state.st == ENG_RST_WR && state.idx == IMG_CSR_IDX
    |=> state.csr == $past(imgRd))
    else $error("control/status not reloaded");

  AST_RESTORE_TAG: assert property (state.st == ENG_RST_WR && state.idx == IMG_TAG_IDX
    |=> state.tagWord == $past(imgRdTag))
    else $error("stack tag not reloaded");

  AST_RST_GUARD: assert property (state.st == ENG_RST_EVAL && imageBad
    |=> idle && protFault && state.status[EV_FAULT] && state.csr == $past(state.csr))
    else $error("bad image changed control/status");

  AST_LOAD_GUARD: assert property (sLoadWr ##0 loadBad
    |=> state.csr == $past(state.csr) && protFault && state.status[EV_FAULT])
    else $error("reserved write not faulted");

  AST_LOAD_OK: assert property (sLoadWr ##0 !loadBad |=> state.csr == $past(busReq.wdata) && !protFault)
    else $error("implemented bits not written");

  AST_NO_RESERVED: assert property (!sscg_has_reserved(state.csr, EFF_MASK))
    else $error("reserved control/status bit set");

  AST_DEF_MASK: assert property (busReq.rd && busReq.addr == OFF_CAP
    |=> readData == EFF_MASK
      && (CAP_MASK_FIELD != CAP_ZERO || (readData == 32'h0000_ffbf && !readData[DENORM_ZERO_BIT])))
    else $error("default capability mask wrong");

endmodule
`default_nettype wire

// file: hdl/sscg_word_mem.sv
// word memory with registered read data, read-before-write
// assumes address below DEPTH; other addresses read zero and drop writes
`timescale 1ns/1ps
`default_nettype none
module sscg_word_mem #(
  parameter int DEPTH = sscg_pkg::IMG_WORDS
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire sscg_pkg::sscg_mem_req_t     req,
  output var  logic [sscg_pkg::DATA_W-1:0] rdata
);
  import sscg_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DATA_W-1:0] words;
    logic [DATA_W-1:0]            rdata;
  } sscg_mem_state_t;

  sscg_mem_state_t state;
  sscg_mem_state_t next_state;

  always_comb begin
    next_state       = state;
    next_state.rdata = '0;
    if (int'(req.addr) < DEPTH) begin
      next_state.rdata = state.words[req.addr];
      if (req.we) begin
        next_state.words[req.addr] = req.wdata;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;

endmodule
`default_nettype wire

// file: shared/sscg_pkg.sv
// shared constants, types and helpers of the vector state save and control/status guard
// assumes one 50 MHz clock and a simple strobe register port
package sscg_pkg;

  // ==========================================================================
  // sizes
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 8;
  localparam int IDX_W     = 7;
  localparam int IMG_BYTES = 512;
  localparam int IMG_WORDS = IMG_BYTES / 4;
  localparam int NUM_EV    = 3;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CMD       = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CSR       = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_CAP       = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ARCH_PTR  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_ARCH_DATA = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_IMG_PTR   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IMG_DATA  = 8'h20;

  // ==========================================================================
  // field positions
  localparam int CMD_SAVE_BIT    = 0;
  localparam int CMD_RESTORE_BIT = 1;
  localparam int CMD_EMPTY_BIT   = 2;
  localparam int EV_SAVE_DONE    = 0;
  localparam int EV_RESTORE_DONE = 1;
  localparam int EV_FAULT        = 2;
  localparam int DENORM_ZERO_BIT = 6;

  // ==========================================================================
  // save image word indices (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IMG_TAG_IDX     = 7'h01;
  localparam logic [IDX_W-1:0] IMG_CSR_IDX     = 7'h06;
  localparam logic [IDX_W-1:0] IMG_CAPMASK_IDX = 7'h07;
  localparam logic [IDX_W-1:0] IMG_FPREG_BASE  = 7'h08;
  localparam logic [IDX_W-1:0] IMG_VREG_BASE   = 7'h28;
  localparam logic [IDX_W-1:0] IMG_LAST_IDX    = 7'h7f;

  // ==========================================================================
  // values after reset and mask defaults
  localparam logic [DATA_W-1:0] CSR_RESET   = 32'h0000_1f80;
  localparam logic [DATA_W-1:0] CAP_ZERO    = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CAP_DEFAULT = 32'h0000_ffbf;
  localparam logic [7:0]        TAG_RESET   = 8'h00;
  localparam logic [7:0]        TAG_EMPTY   = 8'h00;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_SAVE_RD, ENG_SAVE_WR, ENG_RST_CHK, ENG_RST_EVAL, ENG_RST_RD, ENG_RST_WR
  } sscg_eng_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } sscg_bus_req_t;

  typedef struct packed {
    logic              we;
    logic [IDX_W-1:0]  addr;
    logic [DATA_W-1:0] wdata;
  } sscg_mem_req_t;

  typedef struct packed {
    sscg_eng_t         st;
    logic [IDX_W-1:0]  idx;
    logic [DATA_W-1:0] csr;
    logic [7:0]        tagWord;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] irqMask;
    logic [IDX_W-1:0]  archPtr;
    logic [IDX_W-1:0]  imgPtr;
    logic [DATA_W-1:0] readData;
    logic              irq;
    logic              protFault;
    logic              busy;
  } sscg_state_t;

  // ==========================================================================
  // helpers
  function automatic logic [DATA_W-1:0] sscg_eff_mask(input logic [DATA_W-1:0] field);
    return (field == CAP_ZERO) ? CAP_DEFAULT : field;
  endfunction

  function automatic logic sscg_has_reserved(input logic [DATA_W-1:0] val, input logic [DATA_W-1:0] mask);
    return (val & ~mask) != CAP_ZERO;
  endfunction

endpackage

// file: verif/sscg_guard_tb.sv
// testbench of the vector state save and control/status guard
// assumes the default capability field, so the effective mask keeps bit 6 reserved
`timescale 1ns/1ps
`default_nettype none
module sscg_guard_tb;
  import sscg_pkg::*;

  // ==========================================================================
  // design and stimulus
  localparam logic [IDX_W-1:0] TBL [0:5] = '{7'h00, 7'h08, 7'h27, 7'h28, 7'h47, 7'h7f};

  logic              clk;
  logic              sys_rst;
  sscg_bus_req_t     busReq;
  logic [DATA_W-1:0] readData;
  logic              irq;
  logic              protFault;
  logic              busy;
  logic              lastFault;
  logic              sawFault;
  logic [DATA_W-1:0] rdVal;
  logic [DATA_W-1:0] cur;
  logic [DATA_W-1:0] capSeen;
  int                cycles;
  int                failures;
  int                totalChecks;

  sscg_guard #(
    .CAP_MASK_FIELD (32'h0000_0000)
  ) i_dut (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .busReq    (busReq),
    .readData  (readData),
    .irq       (irq),
    .protFault (protFault),
    .busy      (busy)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // report and compare
  task automatic endSim();
    $display("checks made %0d, mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chkWord(input string what, input logic [DATA_W-1:0] expv, input logic [DATA_W-1:0] got);
    totalChecks++;
    if (got !== expv) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, expv, got);
    end
  endtask

  task automatic chkBit(input string what, input logic expv, input logic got);
    totalChecks++;
    if (got !== expv) begin
      failures++;
      $display("wrong value %s: expected %b, seen %b", what, expv, got);
    end
  endtask

  // ==========================================================================
  // register port accesses
  task automatic wrReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    #1;
    lastFault = protFault;
  endtask

  task automatic rdReg(input logic [ADDR_W-1:0] a);
    @(posedge clk);
    busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    busReq <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b0};
    #1;
    rdVal = readData;
  endtask

  // pointer must settle before the registered memory answers
  task automatic rdMem(input logic [ADDR_W-1:0] ptrOff, input logic [IDX_W-1:0] idx);
    wrReg(ptrOff, {25'h0, idx});
    repeat (2) @(posedge clk);
    rdReg(ptrOff + 8'h04);
  endtask

  task automatic wrMem(input logic [ADDR_W-1:0] ptrOff, input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] v);
    wrReg(ptrOff, {25'h0, idx});
    wrReg(ptrOff + 8'h04, v);
  endtask

  task automatic waitIdle();
    cycles = 0;
    sawFault = lastFault;
    while (busy !== 1'b0 && cycles < 400) begin
      @(posedge clk);
      #1;
      sawFault = sawFault | protFault;
      cycles++;
    end
    chkBit("engine finished", 1'b0, busy); // engine ends
  endtask

  task automatic cmdRun(input logic [DATA_W-1:0] cmd);
    wrReg(OFF_CMD, cmd);
    waitIdle();
  endtask

  // ==========================================================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    endSim();
  end

  // ==========================================================================
  // tests
  initial begin
    sys_rst = 1'b1;
    busReq = '0;
    failures = 0;
    totalChecks = 0;
    lastFault = 1'b0;
    sawFault = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdReg(OFF_CSR);
    chkWord("csr after reset", CSR_RESET, rdVal); // no reserved ones
    rdReg(OFF_CAP);
    chkWord("effective mask", CAP_DEFAULT, rdVal); // default mask
    // single-bit writes walk every bit
    cur = CSR_RESET;
    for (int b = 0; b < DATA_W; b++) begin
      wrReg(OFF_CSR, 32'h1 << b);
      chkBit("fault on single bit", ~CAP_DEFAULT[b], lastFault); // zero bits reserved
      if (CAP_DEFAULT[b]) begin
        cur = 32'h1 << b;
      end
      rdReg(OFF_CSR);
      chkWord("csr after single bit", cur, rdVal); // write kept for implemented bits, refused for reserved
    end
    wrReg(OFF_CSR, 32'h0001_1f80);
    chkBit("fault mixed value", 1'b1, lastFault); // reserved one
    rdReg(OFF_CSR);
    chkWord("csr after mixed value", cur, rdVal); // no bit updated
    chkBit("irq while masked", 1'b0, irq); // fault event masked
    wrReg(OFF_IRQ_MASK, 32'h4);
    @(posedge clk);
    #1;
    chkBit("irq on fault", 1'b1, irq); // fault event
    rdReg(OFF_STATUS);
    chkWord("status fault bit", 32'h4, rdVal); // fault recorded
    repeat (2) @(posedge clk);
    #1;
    chkBit("irq after clear", 1'b0, irq); // fault cleared
    rdReg(OFF_STATUS);
    chkWord("status cleared", 32'h0, rdVal); // fault cleared
    // masked write as software should do
    rdReg(OFF_CAP);
    capSeen = (rdVal == 32'h0) ? CAP_DEFAULT : rdVal; // effective mask
    wrReg(OFF_CSR, 32'hdead_beef & capSeen); // masked write
    chkBit("fault on masked write", 1'b0, lastFault); // one bits writable
    rdReg(OFF_CSR);
    chkWord("csr masked write", 32'hdead_beef & CAP_DEFAULT, rdVal); // implemented bits
    // save of a filled state
    wrReg(OFF_IRQ_MASK, 32'h3);
    for (int i = 0; i < 6; i++) begin
      wrMem(OFF_ARCH_PTR, TBL[i], 32'ha5a5_0000 | {25'h0, TBL[i]});
    end
    cmdRun(32'h1); // stack state saved first
    chkWord("save cycles", 32'd256, cycles); // whole image
    @(posedge clk);
    #1;
    chkBit("irq on save done", 1'b1, irq); // save done event
    rdReg(OFF_STATUS);
    chkWord("status save done", 32'h1, rdVal); // save done event
    for (int i = 0; i < 6; i++) begin
      rdMem(OFF_IMG_PTR, TBL[i]);
      chkWord("image word", 32'ha5a5_0000 | {25'h0, TBL[i]}, rdVal); // state in image
    end
    rdMem(OFF_IMG_PTR, IMG_CSR_IDX);
    chkWord("image csr", 32'hdead_beef & CAP_DEFAULT, rdVal); // csr saved
    rdMem(OFF_IMG_PTR, IMG_CAPMASK_IDX);
    chkWord("image mask", 32'h0000_0000, rdVal); // mask bytes 28..31
    // restore of an edited image
    wrMem(OFF_IMG_PTR, IMG_CSR_IDX, 32'h0000_7f80);
    wrMem(OFF_IMG_PTR, IMG_TAG_IDX, 32'h0000_005a);
    wrMem(OFF_IMG_PTR, 7'h28, 32'h1234_5678);
    wrMem(OFF_IMG_PTR, 7'h08, 32'h8765_4321);
    cmdRun(32'h2); // restore run
    chkWord("restore cycles", 32'd258, cycles); // whole image
    rdReg(OFF_STATUS);
    chkWord("status restore done", 32'h2, rdVal); // restore done event
    rdReg(OFF_CSR);
    chkWord("csr restored", 32'h0000_7f80, rdVal); // csr reloaded
    rdMem(OFF_ARCH_PTR, 7'h28);
    chkWord("vector restored", 32'h1234_5678, rdVal); // vector reloaded
    rdMem(OFF_ARCH_PTR, 7'h08);
    chkWord("stack restored", 32'h8765_4321, rdVal); // stack reloaded
    // restore of an image with a reserved one
    wrMem(OFF_IMG_PTR, IMG_CSR_IDX, 32'h0000_1fc0);
    wrMem(OFF_IMG_PTR, 7'h28, 32'hffff_0000);
    cmdRun(32'h2); // bad image restore
    chkBit("fault on bad image", 1'b1, sawFault); // restore refused
    chkWord("bad image cycles", 32'd2, cycles); // early fault
    rdReg(OFF_CSR);
    chkWord("csr after bad image", 32'h0000_7f80, rdVal); // csr kept
    rdMem(OFF_ARCH_PTR, 7'h28);
    chkWord("vector after bad image", 32'h1234_5678, rdVal); // state kept
    rdReg(OFF_STATUS);
    chkWord("status bad image", 32'h4, rdVal); // fault recorded
    wrMem(OFF_IMG_PTR, IMG_CSR_IDX, 32'h0000_7f80);
    // save with accesses while busy
    wrReg(OFF_CMD, 32'h1);
    wrReg(OFF_CSR, 32'h0000_0f80);
    rdReg(OFF_ARCH_DATA);
    chkWord("data read while busy", 32'h0, rdVal); // engine owns memory
    rdReg(OFF_STATUS);
    chkWord("status while busy", 32'h8, rdVal); // busy shown
    waitIdle();
    rdReg(OFF_CSR);
    chkWord("csr write while busy", 32'h0000_7f80, rdVal); // csr held during save
    rdMem(OFF_IMG_PTR, IMG_TAG_IDX);
    chkWord("tag saved", 32'h5a, {24'h0, rdVal[7:0]}); // tag state saved
    // empty command shared with a save
    cmdRun(32'h5); // empty before stack use
    rdMem(OFF_IMG_PTR, IMG_TAG_IDX);
    chkWord("tag emptied", {24'h0, TAG_EMPTY}, {24'h0, rdVal[7:0]}); // tag cleared
    rdMem(OFF_IMG_PTR, 7'h28);
    chkWord("vector after empty", 32'h1234_5678, rdVal); // vector state separate
    // save wins over restore in one command
    rdReg(OFF_STATUS);
    cmdRun(32'h3); // save and restore asked
    chkWord("both commands cycles", 32'd256, cycles); // save wins
    rdReg(OFF_STATUS);
    chkWord("status both commands", 32'h1, rdVal); // save done only
    // unmapped and write-only places
    wrReg(8'h40, 32'hffff_ffff);
    rdReg(8'h40);
    chkWord("unmapped read", 32'h0, rdVal); // no stray state
    rdReg(OFF_CMD);
    chkWord("command read", 32'h0, rdVal); // no stray state
    endSim();
  end
endmodule
`default_nettype wire
